// >>> rtl/vsos_pkg.sv
package vsos_pkg;

	// ---------------------------------------------------------------
	// Slicer source select codes
	// ---------------------------------------------------------------
	localparam logic [1:0] SLICE_RAW_GREEN   = 2'h0;
	localparam logic [1:0] SLICE_RAW_LINE    = 2'h1;
	localparam logic [1:0] SLICE_REGEN_LINE  = 2'h2;
	localparam logic [1:0] SLICE_FILT_LINE   = 2'h3;

	// ---------------------------------------------------------------
	// Widths, reset values and cycle counts
	// ---------------------------------------------------------------
	localparam int         LINE_WIDTH_BITS   = 8;
	localparam int         FRAME_WIDTH_BITS  = 8;
	localparam logic [7:0] LINE_WIDTH_RST    = 8'h20;
	localparam logic [7:0] FRAME_WIDTH_RST   = 8'h04;
	localparam int         EDGE_GUARD_CYCLES = 16;
	localparam int         ADDR_SAMPLE_CYCLES = 4;

endpackage

// >>> rtl/vsos_pulse_gen.sv
`timescale 1ns/1ns
// Retriggerable one-shot: a start pulse opens a window of 'width' counts of tick.
module vsos_pulse_gen #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic         start,
	input  wire logic         tick,
	input  wire logic [W-1:0] width,
	output logic              active
);

	logic [W-1:0] count_r;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			count_r <= '0;
			active  <= 1'b0;
		end
		else if (start)
		begin
			count_r <= width;
			active  <= (width != '0);
		end
		else if (tick && active)
		begin
			count_r <= count_r - 1'b1;
			active  <= (count_r > {{(W-1){1'b0}}, 1'b1});
		end
	end

endmodule

// >>> rtl/vsos_sync_out.sv
`timescale 1ns/1ns
// Summary of operation
// [RULE_01] The line sync output is regenerated from incoming horizontal sync and retimed to clk.
// [RULE_02] Line sync polarity and pulse width are programmable by configuration ports.
// [RULE_03] Line sync, pixel clock output and pixel data leave through the same register stage.
// [RULE_04] Frame sync is either separated from composite sync or the vertical input passed through.
// [RULE_05] One polarity bit inverts the frame sync output.
// [RULE_06] Frame sync follows the source width, or when enabled a programmed width.
// [RULE_07] Address-select sampling does not disturb the frame sync output.
// [RULE_08] After reset the shared pin level is captured as the bus address least significant bit.
// [RULE_09] The slicer output carries one of four sources chosen by a two-bit field.
// [RULE_10] The slicer output gets no processing beyond selection; separation is elsewhere.
// [RULE_11] A field indicator shows odd or even field for interlaced input.
// [RULE_12] Select codes zero to three map to raw green, raw line, regenerated line, filtered line.
// [RULE_13] The field indicator changes only at the start of a new field.
module vsos_sync_out #(
	parameter int LW = vsos_pkg::LINE_WIDTH_BITS,
	parameter int FW = vsos_pkg::FRAME_WIDTH_BITS
) (
	input  wire logic          clk,
	input  wire logic          sys_rst,
	input  wire logic          lineSyncIn,
	input  wire logic          frameSyncIn,
	input  wire logic          syncOnGreen,
	input  wire logic          filtLineSync,
	input  wire logic          pixelClkEn,
	input  wire logic [7:0]    pixelDataIn,
	input  wire logic          lineSyncPolInv,
	input  wire logic [LW-1:0] lineSyncWidth,
	input  wire logic          frameSyncPolInv,
	input  wire logic          frameSyncUseSep,
	input  wire logic          frameSyncFixWidth,
	input  wire logic [FW-1:0] frameSyncWidth,
	input  wire logic [1:0]    slicerSelect,
	input  wire logic          addrPinIn,
	output logic               line_sync_out,
	output logic               frame_sync_out,
	output logic               frame_sync_out_oe,
	output logic               green_sync_slicer_out,
	output logic               pixel_data_clock_out,
	output logic [7:0]         pixelDataOut,
	output logic               oddEvenField,
	output logic               bus_addr_select_lsb
);

	// ---------------------------------------------------------------
	// Input synchronisers
	// ---------------------------------------------------------------
	logic [1:0] lineSync_r;
	logic [1:0] frameSync_r;
	logic [1:0] green_r;
	logic [1:0] filt_r;
	logic [1:0] addrPin_r;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			lineSync_r  <= 2'h0;
			frameSync_r <= 2'h0;
			green_r     <= 2'h0;
			filt_r      <= 2'h0;
			addrPin_r   <= 2'h0;
		end
		else
		begin
			lineSync_r  <= {lineSync_r[0], lineSyncIn};
			frameSync_r <= {frameSync_r[0], frameSyncIn};
			green_r     <= {green_r[0], syncOnGreen};
			filt_r      <= {filt_r[0], filtLineSync};
			addrPin_r   <= {addrPin_r[0], addrPinIn};
		end
	end

	logic lineSyncS;
	logic frameSyncS;
	logic greenS;
	logic filtS;
	assign lineSyncS  = lineSync_r[1];
	assign frameSyncS = frameSync_r[1];
	assign greenS     = green_r[1];
	assign filtS      = filt_r[1];

	// ---------------------------------------------------------------
	// Edge detection
	// ---------------------------------------------------------------
	logic lineSyncD_r;
	logic frameSyncD_r;
	logic sepVsD_r;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			lineSyncD_r  <= 1'b0;
			frameSyncD_r <= 1'b0;
		end
		else
		begin
			lineSyncD_r  <= lineSyncS;
			frameSyncD_r <= frameSyncS;
		end
	end

	logic lineRise;
	assign lineRise = lineSyncS && !lineSyncD_r;

	// ---------------------------------------------------------------
	// Line sync regeneration
	// ---------------------------------------------------------------
	logic lineRegen;

	vsos_pulse_gen #(
		.W (LW)
	) u_line_pulse (
		.clk     (clk),
		.sys_rst (sys_rst),
		.start   (lineRise),
		.tick    (1'b1),
		.width   (lineSyncWidth),
		.active  (lineRegen)
	); // RULE_01

	// ---------------------------------------------------------------
	// Vertical separation from composite sync on the green input
	// ---------------------------------------------------------------
	// A composite pulse held longer than a normal line sync is taken as vertical sync.
	logic [4:0] greenHigh_r;
	logic       sepVs_r;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			greenHigh_r <= 5'h00;
			sepVs_r     <= 1'b0;
		end
		else if (!greenS)
		begin
			greenHigh_r <= 5'h00;
			sepVs_r     <= 1'b0;
		end
		else if (greenHigh_r < 5'(vsos_pkg::EDGE_GUARD_CYCLES))
			greenHigh_r <= greenHigh_r + 5'h01;
		else
			sepVs_r     <= 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			sepVsD_r <= 1'b0;
		else
			sepVsD_r <= sepVs_r;
	end

	logic srcFrame;
	logic srcFrameRise;
	assign srcFrame     = frameSyncUseSep ? sepVs_r : frameSyncS; // RULE_04
	assign srcFrameRise = frameSyncUseSep ? (sepVs_r && !sepVsD_r)
	                                      : (frameSyncS && !frameSyncD_r);

	// ---------------------------------------------------------------
	// Frame sync width and field detection
	// ---------------------------------------------------------------
	logic frameFixed;
	logic frameShaped;

	vsos_pulse_gen #(
		.W (FW)
	) u_frame_pulse (
		.clk     (clk),
		.sys_rst (sys_rst),
		.start   (srcFrameRise),
		.tick    (lineRise),
		.width   (frameSyncWidth),
		.active  (frameFixed)
	);

	assign frameShaped = frameSyncFixWidth ? frameFixed : srcFrame; // RULE_06

	// Odd field when frame sync starts while line sync is high.
	logic lineAtFrame;
	assign lineAtFrame = lineSyncS;

	// ---------------------------------------------------------------
	// Address strap capture
	// ---------------------------------------------------------------
	logic [2:0] strapCnt_r;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			strapCnt_r          <= 3'h0;
			bus_addr_select_lsb <= 1'b0;
		end
		else if (strapCnt_r < 3'(vsos_pkg::ADDR_SAMPLE_CYCLES))
		begin
			strapCnt_r          <= strapCnt_r + 3'h1;
			bus_addr_select_lsb <= addrPin_r[1]; // RULE_08
		end
	end

	// ---------------------------------------------------------------
	// Output register stage
	// ---------------------------------------------------------------
	// All pixel-side outputs share one register so their alignment is fixed.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			line_sync_out        <= 1'b0;
			pixel_data_clock_out <= 1'b0;
			pixelDataOut         <= 8'h00;
		end
		else
		begin
			line_sync_out        <= lineRegen ^ lineSyncPolInv; // RULE_02
			pixel_data_clock_out <= pixelClkEn; // RULE_03
			pixelDataOut         <= pixelDataIn; // RULE_03
		end
	end

	// The pin is driven from the first clock after reset; strap reading uses the input side only.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			frame_sync_out    <= 1'b0;
			frame_sync_out_oe <= 1'b0;
		end
		else
		begin
			frame_sync_out    <= frameShaped ^ frameSyncPolInv; // RULE_05
			frame_sync_out_oe <= 1'b1; // RULE_07
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			green_sync_slicer_out <= 1'b0;
		else
			case (slicerSelect) // RULE_09
				vsos_pkg::SLICE_RAW_GREEN:  green_sync_slicer_out <= greenS; // RULE_12
				vsos_pkg::SLICE_RAW_LINE:   green_sync_slicer_out <= lineSyncS;
				vsos_pkg::SLICE_REGEN_LINE: green_sync_slicer_out <= lineRegen;
				default:                    green_sync_slicer_out <= filtS; // RULE_10
			endcase
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			oddEvenField <= 1'b0;
		else if (srcFrameRise) // RULE_13
			oddEvenField <= lineAtFrame; // RULE_11
	end

endmodule

// >>> tb/vsos_sync_out_assertions.sv
`timescale 1ns/1ns
module vsos_sync_out_assertions #(
	parameter int LW = 8
) (
	input wire logic          clk,
	input wire logic          sys_rst,
	input wire logic          lineSyncIn,
	input wire logic          frameSyncIn,
	input wire logic          syncOnGreen,
	input wire logic          filtLineSync,
	input wire logic [7:0]    pixelDataIn,
	input wire logic          lineSyncPolInv,
	input wire logic [LW-1:0] lineSyncWidth,
	input wire logic          frameSyncPolInv,
	input wire logic          frameSyncUseSep,
	input wire logic          frameSyncFixWidth,
	input wire logic [1:0]    slicerSelect,
	input wire logic          line_sync_out,
	input wire logic          frame_sync_out,
	input wire logic          frame_sync_out_oe,
	input wire logic          green_sync_slicer_out,
	input wire logic [7:0]    pixelDataOut,
	input wire logic          oddEvenField,
	input wire logic          bus_addr_select_lsb
);
	logic [3:0]    age;
	logic [3:0]    frAge;
	logic [LW-1:0] run;
	logic          polQ;
	logic          frQ;
	wire           act = line_sync_out != polQ;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// The output register sees last cycle's polarity, so the active level is judged with it.
	always_ff @(posedge clk)
	begin
		polQ <= lineSyncPolInv;
		frQ <= frameSyncIn;
		run <= act ? run + 1'b1 : '0;
		age <= sys_rst ? 4'h0 : age + {3'h0, age != 4'hF};
		frAge <= sys_rst | (frameSyncIn & ~frQ) ? 4'h0 : frAge + {3'h0, frAge != 4'hF};
	end
	a_oe_driven: assert property (age > 4'h0 |-> frame_sync_out_oe)
		else $error("frame oe low");
	a_pixel_stage: assert property (age > 4'h1 |-> pixelDataOut == $past(pixelDataIn))
		else $error("pixel data stage");
	a_slicer_route: assert property ((age > 4'h4 && $stable(slicerSelect)
		&& slicerSelect != 2'h2) [*4] |-> green_sync_slicer_out == $past(slicerSelect == 2'h0
		? syncOnGreen : slicerSelect == 2'h1 ? lineSyncIn : filtLineSync, 3))
		else $error("slicer source");
	a_line_start: assert property ($rose(lineSyncIn) && lineSyncWidth != '0
		&& age > 4'h4 |-> ##[3:5] act)
		else $error("line sync late");
	a_line_width: assert property ($fell(act) && age > 4'h8 |-> run == lineSyncWidth)
		else $error("line sync width");
	a_frame_pass: assert property ($rose(frameSyncIn) && !frameSyncUseSep
		&& !frameSyncFixWidth |-> ##[2:6] frame_sync_out != frameSyncPolInv)
		else $error("frame sync pass");
	a_field_edge: assert property ($changed(oddEvenField) && age > 4'h2 |-> frAge < 4'h8)
		else $error("field changed mid field");
	a_strap_held: assert property (age > 4'h6 |-> $stable(bus_addr_select_lsb))
		else $error("address lsb moved");
endmodule
bind vsos_sync_out vsos_sync_out_assertions #(.LW(LW)) vsos_sync_out_assertions_i (
	.clk                   (clk),
	.sys_rst               (sys_rst),
	.lineSyncIn            (lineSyncIn),
	.frameSyncIn           (frameSyncIn),
	.syncOnGreen           (syncOnGreen),
	.filtLineSync          (filtLineSync),
	.pixelDataIn           (pixelDataIn),
	.lineSyncPolInv        (lineSyncPolInv),
	.lineSyncWidth         (lineSyncWidth),
	.frameSyncPolInv       (frameSyncPolInv),
	.frameSyncUseSep       (frameSyncUseSep),
	.frameSyncFixWidth     (frameSyncFixWidth),
	.slicerSelect          (slicerSelect),
	.line_sync_out         (line_sync_out),
	.frame_sync_out        (frame_sync_out),
	.frame_sync_out_oe     (frame_sync_out_oe),
	.green_sync_slicer_out (green_sync_slicer_out),
	.pixelDataOut          (pixelDataOut),
	.oddEvenField          (oddEvenField),
	.bus_addr_select_lsb   (bus_addr_select_lsb)
);

// >>> tb/vsos_display_sink.sv
`timescale 1ns/1ns
// Downstream logic: keeps the pixel strobed in when a line starts.
module vsos_display_sink (
	input  wire logic       clk,
	input  wire logic       lineActive,
	input  wire logic       pixStrobe,
	input  wire logic [7:0] pixData,
	output logic [7:0]      lineData
);
	logic lineQ;
	always_ff @(posedge clk)
	begin
		lineQ <= lineActive;
		if (lineActive && !lineQ && pixStrobe)
			lineData <= pixData;
	end
endmodule

// >>> tb/tb.sv
`timescale 1ns/1ns
module tb;
	logic       clk, sys_rst, lineSyncIn, frameSyncIn, syncOnGreen, filtLineSync, pixelClkEn;
	logic       lineSyncPolInv, frameSyncPolInv, frameSyncUseSep, frameSyncFixWidth, addrPinIn;
	logic [7:0] pixelDataIn, lineSyncWidth, frameSyncWidth, pixelDataOut, lineData, n;
	logic [1:0] slicerSelect;
	logic       line_sync_out, frame_sync_out, frame_sync_out_oe, green_sync_slicer_out;
	logic       pixel_data_clock_out, oddEvenField, bus_addr_select_lsb;
	int         num_errors, samples_checked, cycles;
	localparam logic [5:0] SL [7] = '{6'h09, 6'h06, 6'h15, 6'h1A, 6'h2A, 6'h33, 6'h3C};
	localparam logic [7:0] WD [4] = '{8'h01, 8'h05, 8'h00, vsos_pkg::LINE_WIDTH_RST};
	vsos_sync_out vsos_sync_out_i (
		.clk                   (clk),
		.sys_rst               (sys_rst),
		.lineSyncIn            (lineSyncIn),
		.frameSyncIn           (frameSyncIn),
		.syncOnGreen           (syncOnGreen),
		.filtLineSync          (filtLineSync),
		.pixelClkEn            (pixelClkEn),
		.pixelDataIn           (pixelDataIn),
		.lineSyncPolInv        (lineSyncPolInv),
		.lineSyncWidth         (lineSyncWidth),
		.frameSyncPolInv       (frameSyncPolInv),
		.frameSyncUseSep       (frameSyncUseSep),
		.frameSyncFixWidth     (frameSyncFixWidth),
		.frameSyncWidth        (frameSyncWidth),
		.slicerSelect          (slicerSelect),
		.addrPinIn             (addrPinIn),
		.line_sync_out         (line_sync_out),
		.frame_sync_out        (frame_sync_out),
		.frame_sync_out_oe     (frame_sync_out_oe),
		.green_sync_slicer_out (green_sync_slicer_out),
		.pixel_data_clock_out  (pixel_data_clock_out),
		.pixelDataOut          (pixelDataOut),
		.oddEvenField          (oddEvenField),
		.bus_addr_select_lsb   (bus_addr_select_lsb)
	);
	vsos_display_sink vsos_display_sink_i (.clk(clk), .lineActive(line_sync_out ^ lineSyncPolInv),
		.pixStrobe(pixel_data_clock_out), .pixData(pixelDataOut), .lineData(lineData));
	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			num_errors++;
			test_done();
		end
	end
	initial
	begin
		{sys_rst, addrPinIn, pixelClkEn, lineSyncIn, frameSyncIn, syncOnGreen} = 6'h38;
		{filtLineSync, lineSyncPolInv, frameSyncPolInv, frameSyncUseSep} = 4'h0;
		{frameSyncFixWidth, slicerSelect, pixelDataIn, lineSyncWidth} = 19'h0;
		frameSyncWidth = 8'h02;
		num_errors = 0;
		samples_checked = 0;
		cycles = 0;
		cyc(6);
		sys_rst = 1'b0;
		cyc(8);
		chk("addrLsb", bus_addr_select_lsb, 1'b1);
		addrPinIn = 1'b0;
		cyc(4);
		chk("addrLsbHeld", bus_addr_select_lsb, 1'b1);
		pixelClkEn = 1'b0;
		cyc(2);
		chk("pixelClk", pixel_data_clock_out, 1'b0);
		pixelClkEn = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			lineSyncWidth = WD[i];
			lineSyncPolInv = i[0];
			pixelDataIn = 8'hA0 + 8'(i);
			cyc(3);
			chk("pixelData", pixelDataOut, 8'hA0 + 8'(i));
			lineSyncIn = 1'b1;
			cyc(2);
			lineSyncIn = 1'b0;
			n = 8'h00;
			repeat (60)
			begin
				cyc(1);
				n += 8'(line_sync_out != lineSyncPolInv);
			end
			chk("lineWidth", n, WD[i]);
			if (WD[i] != 8'h00)
				chk("lineStartData", lineData, 8'hA0 + 8'(i));
		end
		lineSyncWidth = 8'h01;
		lineSyncPolInv = 1'b0;
		for (int i = 0; i < 7; i++)
		begin
			{slicerSelect, syncOnGreen, lineSyncIn, filtLineSync} = SL[i][5:1];
			cyc(7);
			chk("slicer", green_sync_slicer_out, SL[i][0]);
		end
		{syncOnGreen, lineSyncIn, filtLineSync} = 3'h0;
		slicerSelect = vsos_pkg::SLICE_REGEN_LINE;
		lineSyncWidth = 8'h05;
		cyc(4);
		lineSyncIn = 1'b1;
		cyc(2);
		lineSyncIn = 1'b0;
		n = 8'h00;
		repeat (12)
		begin
			cyc(1);
			n += 8'(green_sync_slicer_out);
		end
		chk("slicerRegen", n, 8'h05);
		for (int p = 0; p < 2; p++)
		begin
			frameSyncPolInv = p[0];
			cyc(4);
			frameSyncIn = 1'b1;
			cyc(8);
			chk("frameActive", frame_sync_out, !p[0]);
			frameSyncIn = 1'b0;
			cyc(8);
			chk("frameIdle", frame_sync_out, p[0]);
		end
		frameSyncPolInv = 1'b0;
		frameSyncUseSep = 1'b1;
		syncOnGreen = 1'b1;
		cyc(30);
		chk("frameSeparated", frame_sync_out, 1'b1);
		syncOnGreen = 1'b0;
		frameSyncUseSep = 1'b0;
		cyc(30);
		frameSyncFixWidth = 1'b1;
		frameSyncIn = 1'b1;
		n = 8'h00;
		repeat (6)
		begin
			lineSyncIn = 1'b1;
			cyc(3);
			lineSyncIn = 1'b0;
			cyc(5);
			n += 8'(frame_sync_out);
		end
		chk("fixedSeen", n, 8'h02);
		chk("fixedEnded", frame_sync_out, 1'b0);
		frameSyncIn = 1'b0;
		frameSyncFixWidth = 1'b0;
		cyc(8);
		frameSyncIn = 1'b1;
		cyc(8);
		chk("fieldEven", oddEvenField, 1'b0);
		frameSyncIn = 1'b0;
		lineSyncIn = 1'b1;
		cyc(4);
		frameSyncIn = 1'b1;
		cyc(8);
		chk("fieldOdd", oddEvenField, 1'b1);
		lineSyncIn = 1'b0;
		cyc(8);
		chk("fieldHeld", oddEvenField, 1'b1);
		test_done();
	end
endmodule
